//--- verilog/fflc_top.sv
// Purpose: fill level counters for a queue with a write and a read port
// Assumes: user write and read logic on aclk; register access by AXI4-Lite
// Notes: pointers cross sides through gray synchronisers
// How it works
// R1 - write count never under-reports stored words; approximate style saturates at lim and so under-reports a full queue
// R2 - narrow write count keeps the upper bits
// R3 - write visible after following edge
// R4 - look-ahead adds two read words capacity
// R5 - approximate style keeps log2 depth widths
// R6 - user may read approximate top bit
// R7 - accurate style counts one bit wider
// R8 - user needs top two bits, accurate
// R9 - single count exact except near empty
// R10 - single count exact from write port
// R11 - single count over-reports two until released
// R12 - exact once near-empty released
// R13 - accurate write count adds two read words
// R14 - over-report holds until near-empty released
// R15 - settling may skip or drop counts
// R16 - counts read zero during reset
// R17 - empty values follow depth ratio
// R18 - read count zero when empty
// R19 - count only accepted writes and reads
// R20 - read visible one cycle later
// R21 - read count never over-reports
// R22 - single count moves on same edge
// R23 - refused requests leave counts alone
// R24 - crossing counts use gray pointers
`timescale 1ns/100ps

module fflc_top
   import fflc_pkg::*;
#(
   parameter int WR_DEPTH_LOG = 4,
   parameter int WR_UNIT_LOG = 0,
   parameter int RD_UNIT_LOG = 0,
   parameter int WR_CNT_W = WR_DEPTH_LOG + 1,
   parameter int RD_CNT_W = WR_DEPTH_LOG + WR_UNIT_LOG - RD_UNIT_LOG + 1,
   parameter int DATA_CNT_W = WR_DEPTH_LOG + 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic full,
   output logic empty,
   output logic [WR_CNT_W-1:0] wr_count,
   output logic [RD_CNT_W-1:0] rd_count,
   output logic [DATA_CNT_W-1:0] data_count,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // ****************************************
   // sizes; U, WRU, CAP and EXTRA in units of the narrower word
   // ****************************************
   localparam int U = WR_DEPTH_LOG + WR_UNIT_LOG;
   localparam int RM = U - RD_UNIT_LOG;
   localparam int WM = WR_DEPTH_LOG;
   localparam int PU = U + 2;
   localparam int PW = PU - WR_UNIT_LOG;
   localparam int PR = PU - RD_UNIT_LOG;
   localparam logic [PU-1:0] WRU = PU'(1) << WR_UNIT_LOG;
   localparam logic [PU-1:0] CAP = PU'(1) << U;
   localparam logic [PU-1:0] EXTRA = PU'(`FFLC_LA_EXTRA_WORDS) << RD_UNIT_LOG;

   typedef struct packed {
      fflc_ctrl_s ctrl;
      fflc_wst_e wst;
      fflc_rst_e rdst;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic wstrb0;
      logic [1:0] bresp;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [PW-1:0] wptr;
      logic [PR-1:0] rptr;
      logic full;
      logic empty;
      logic aempty;
      logic hold_s1;
      logic hold_s2;
      logic [PU-1:0] wc;
      logic [PU-1:0] rc;
      logic [PU-1:0] dc;
      logic [WR_CNT_W-1:0] wr_count;
      logic [RD_CNT_W-1:0] rd_count;
      logic [DATA_CNT_W-1:0] data_count;
   } fflc_state_s;

   localparam fflc_state_s ST_RST = '{
      ctrl: `FFLC_CTRL_RST_VAL,
      wst: WS_IDLE,
      rdst: RS_IDLE,
      full: 1'b1,
      empty: 1'b1,
      aempty: 1'b1,
      hold_s1: 1'b1,
      hold_s2: 1'b1,
      default: '0
   };

   fflc_state_s s_q;
   fflc_state_s s_d;
   logic [PR-1:0] rsync;
   logic [PW-1:0] wsync;
   logic wr_ok;
   logic rd_ok;
   logic [PU-1:0] ex_units;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [PU-1:0] wu(input logic [PW-1:0] p);
      return PU'(p) << WR_UNIT_LOG;
   endfunction

   function automatic logic [PU-1:0] ru(input logic [PR-1:0] p);
      return PU'(p) << RD_UNIT_LOG;
   endfunction

   // scale a word count onto an output of w bits for log2 depth m
   function automatic logic [PU-1:0] fit(input logic [PU-1:0] v, input int m,
                                         input logic acc, input int w);
      logic [PU-1:0] lim;
      logic [PU-1:0] r;
      lim = (PU'(1) << m) - PU'(1);
      if (acc) begin
         r = v >> (m + 1 - w); // R7 R2
      end else begin
         r = (v > lim) ? lim : v; // R5
         r = r >> ((w >= m) ? 0 : m - w); // R2
      end
      return r;
   endfunction

   // ****************************************
   // pointer crossing
   // ****************************************
   // read pointer seen from the write side
   fflc_ptr_sync #(.W(PR)) u_rsync ( // R24
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(s_q.ctrl.fifo_rst),
      .bin_in(s_q.rptr),
      .bin_out(rsync)
   );

   // write pointer seen from the read side
   fflc_ptr_sync #(.W(PW)) u_wsync ( // R24
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(s_q.ctrl.fifo_rst),
      .bin_in(s_q.wptr),
      .bin_out(wsync)
   );

   // accepted requests only
   assign wr_ok = wr_en && !s_q.full && !s_q.ctrl.fifo_rst; // R19 R23
   assign rd_ok = rd_en && !s_q.empty && !s_q.ctrl.fifo_rst; // R19 R23
   assign ex_units = wu(s_q.wptr) - ru(s_q.rptr);

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic la;
      logic acc;
      logic [PU-1:0] cap;
      logic [PU-1:0] wun;
      logic [PU-1:0] wun_n;
      logic [PU-1:0] run;
      logic [PU-1:0] rw_n;
      logic [PU-1:0] xw;
      logic [PU-1:0] xd;
      logic [PU-1:0] t;
      logic [7:0] wa;
      logic [31:0] wd;
      logic ws;
      logic do_wr;
      la = s_q.ctrl.lookahead_read_mode;
      acc = s_q.ctrl.accurate;
      s_d = s_q;
      s_d.wptr = s_q.wptr + PW'(wr_ok);
      s_d.rptr = s_q.rptr + PR'(rd_ok);
      // write side works from the stale read pointer, so it errs high
      cap = CAP + (la ? EXTRA : '0); // R4
      wun = wu(s_q.wptr) - ru(rsync); // R1
      wun_n = wu(s_d.wptr) - ru(rsync);
      s_d.full = (wun_n + WRU) > cap;
      // read side works from the stale write pointer, so it errs low
      run = wu(wsync) - ru(s_q.rptr); // R21
      rw_n = (wu(wsync) - ru(s_d.rptr)) >> RD_UNIT_LOG;
      s_d.empty = (rw_n == '0);
      s_d.aempty = (rw_n <= PU'(1));
      // near-empty release crosses back as a level; R15 covers the lag
      s_d.hold_s1 = s_q.aempty; // R15
      s_d.hold_s2 = s_q.hold_s1;
      // two read words stay counted until the release arrives
      xw = (la && acc && s_q.hold_s2) ? EXTRA : '0; // R13 R14 R17
      s_d.wc = (wun + xw) >> WR_UNIT_LOG; // R3
      t = fit(s_d.wc, WM, acc, WR_CNT_W);
      s_d.wr_count = t[WR_CNT_W-1:0];
      s_d.rc = run >> RD_UNIT_LOG; // R20 R18
      t = fit(s_d.rc, RM, acc, RD_CNT_W);
      s_d.rd_count = t[RD_CNT_W-1:0];
      // single count from the next pointers moves on the same edge
      xd = (la && acc && s_q.aempty) ? EXTRA : '0; // R9 R11 R12
      s_d.dc = wu(s_d.wptr) - ru(s_d.rptr) + xd; // R10 R22
      t = fit(s_d.dc, WM, 1'b1, DATA_CNT_W);
      s_d.data_count = t[DATA_CNT_W-1:0];
      // write channel: address and data in either order
      wa = (s_q.wst == WS_GOTA) ? s_q.awaddr : s_axi_awaddr;
      wd = (s_q.wst == WS_GOTW) ? s_q.wdata : s_axi_wdata;
      ws = (s_q.wst == WS_GOTW) ? s_q.wstrb0 : s_axi_wstrb[0];
      do_wr = 1'b0;
      case (s_q.wst)
         WS_IDLE: begin
            if (s_axi_awvalid && s_axi_wvalid) begin
               do_wr = 1'b1;
            end else if (s_axi_awvalid) begin
               s_d.awaddr = s_axi_awaddr;
               s_d.wst = WS_GOTA;
            end else if (s_axi_wvalid) begin
               s_d.wdata = s_axi_wdata;
               s_d.wstrb0 = s_axi_wstrb[0];
               s_d.wst = WS_GOTW;
            end
         end
         WS_GOTA: begin
            do_wr = s_axi_wvalid;
         end
         WS_GOTW: begin
            do_wr = s_axi_awvalid;
         end
         WS_RESP: begin
            if (s_axi_bready) begin
               s_d.wst = WS_IDLE;
            end
         end
         default: begin
            s_d.wst = WS_IDLE;
         end
      endcase
      if (do_wr) begin
         s_d.wst = WS_RESP;
         s_d.bresp = `FFLC_RESP_OKAY;
         case (wa)
            `FFLC_OFS_CTRL: begin
               if (ws) begin
                  s_d.ctrl = wd[`FFLC_CTRL_W-1:0];
               end
            end
            `FFLC_OFS_WCOUNT, `FFLC_OFS_RCOUNT,
            `FFLC_OFS_DCOUNT, `FFLC_OFS_FLAGS: begin
               s_d.bresp = `FFLC_RESP_OKAY; // read-only, write ignored
            end
            default: begin
               s_d.bresp = `FFLC_RESP_SLVERR;
            end
         endcase
      end
      // read channel: data registered one cycle after address
      case (s_q.rdst)
         RS_IDLE: begin
            if (s_axi_arvalid) begin
               s_d.rdst = RS_DATA;
               s_d.rresp = `FFLC_RESP_OKAY;
               s_d.rdata = '0;
               case (s_axi_araddr)
                  `FFLC_OFS_CTRL: s_d.rdata = 32'(s_q.ctrl);
                  `FFLC_OFS_WCOUNT: s_d.rdata = 32'(s_q.wr_count);
                  `FFLC_OFS_RCOUNT: s_d.rdata = 32'(s_q.rd_count);
                  `FFLC_OFS_DCOUNT: s_d.rdata = 32'(s_q.data_count);
                  `FFLC_OFS_FLAGS: begin
                     s_d.rdata[`FFLC_FLAG_FULL] = s_q.full;
                     s_d.rdata[`FFLC_FLAG_EMPTY] = s_q.empty;
                     s_d.rdata[`FFLC_FLAG_AEMPTY] = s_q.aempty;
                  end
                  default: s_d.rresp = `FFLC_RESP_SLVERR;
               endcase
            end
         end
         RS_DATA: begin
            if (s_axi_rready) begin
               s_d.rdst = RS_IDLE;
            end
         end
         default: begin
            s_d.rdst = RS_IDLE;
         end
      endcase
      // queue reset: counts to zero, both ports refuse
      if (s_q.ctrl.fifo_rst) begin
         s_d.wptr = '0;
         s_d.rptr = '0;
         s_d.full = 1'b1;
         s_d.empty = 1'b1;
         s_d.aempty = 1'b1;
         s_d.wc = '0; // R16
         s_d.rc = '0;
         s_d.dc = '0;
         s_d.wr_count = '0; // R16
         s_d.rd_count = '0;
         s_d.data_count = '0; // R16
      end
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= ST_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs
   assign full = s_q.full;
   assign empty = s_q.empty;
   assign wr_count = s_q.wr_count;
   assign rd_count = s_q.rd_count;
   assign data_count = s_q.data_count;
   assign s_axi_awready = (s_q.wst == WS_IDLE) || (s_q.wst == WS_GOTW);
   assign s_axi_wready = (s_q.wst == WS_IDLE) || (s_q.wst == WS_GOTA);
   assign s_axi_bvalid = (s_q.wst == WS_RESP);
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = (s_q.rdst == RS_IDLE);
   assign s_axi_rvalid = (s_q.rdst == RS_DATA);
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   logic [PU-1:0] ex_w;
   logic [PU-1:0] ex_r;
   logic ex_zero;
   logic quiet;
   assign ex_w = ex_units >> WR_UNIT_LOG;
   assign ex_r = ex_units >> RD_UNIT_LOG;
   assign ex_zero = (ex_units == '0);
   assign quiet = !s_q.ctrl.fifo_rst && s_q.ctrl.accurate;

   sequence s_wr_quiet;
      wr_ok && quiet && !s_q.ctrl.lookahead_read_mode
      ##1 $stable(rsync) && !wr_ok && quiet;
   endsequence

   sequence s_rd_quiet;
      rd_ok && quiet ##1 $stable(wsync) && !rd_ok && quiet;
   endsequence

   AST_WR_NEVER_UNDER: assert property ( // R1
      quiet && $past(quiet) |-> s_q.wc >= $past(ex_w))
      else $error("write count below stored words");

   AST_WR_SEEN: assert property ( // R3
      s_wr_quiet |=> s_q.wc == $past(s_q.wc) + PU'(1))
      else $error("write not seen after following edge");

   AST_RD_SEEN: assert property ( // R20
      s_rd_quiet |=> s_q.rc == $past(s_q.rc) - PU'(1))
      else $error("read not seen one cycle later");

   AST_RD_NEVER_OVER: assert property ( // R21
      quiet && $past(quiet) |-> s_q.rc <= $past(ex_r))
      else $error("read count above readable words");

   AST_FULL_REFUSED: assert property ( // R23
      s_q.full && wr_en && !s_q.ctrl.fifo_rst |=> $stable(s_q.wptr))
      else $error("write taken while full");

   AST_EMPTY_REFUSED: assert property ( // R23
      s_q.empty && rd_en && !s_q.ctrl.fifo_rst |=> $stable(s_q.rptr))
      else $error("read taken while empty");

   AST_RESET_ZERO: assert property ( // R16
      s_q.ctrl.fifo_rst |=> wr_count == '0 && data_count == '0)
      else $error("count not zero in queue reset");

   AST_EMPTY_RD_ZERO: assert property ( // R18
      $past(ex_zero) && !$past(s_q.ctrl.fifo_rst) |-> s_q.rc == '0)
      else $error("read count not zero when empty");

   AST_DC_SAME_EDGE: assert property ( // R22
      wr_ok && !rd_ok && !s_q.ctrl.lookahead_read_mode
      |=> s_q.dc == $past(s_q.dc) + PU'(1))
      else $error("single count missed write edge");

   AST_WR_EXTRA: assert property ( // R14
      quiet && s_q.ctrl.lookahead_read_mode && s_q.hold_s2
      |=> s_q.wc >= $past(ex_w) + (EXTRA >> WR_UNIT_LOG))
      else $error("write count lost look-ahead words");

endmodule

//--- verilog/fflc_defines.svh
// Purpose: register offsets, field positions, reset values and counts
// Assumes: included by the package and by the bench top
// Notes: definitions only
`ifndef FFLC_DEFINES_SVH
`define FFLC_DEFINES_SVH

// ****************************************
// register map
// ****************************************
`define FFLC_ADDR_W 8
`define FFLC_OFS_CTRL 8'h00
`define FFLC_OFS_WCOUNT 8'h04
`define FFLC_OFS_RCOUNT 8'h08
`define FFLC_OFS_DCOUNT 8'h0C
`define FFLC_OFS_FLAGS 8'h10

// ****************************************
// fields and reset values
// ****************************************
`define FFLC_CTRL_W 3
`define FFLC_CTRL_RST_VAL 3'h0
`define FFLC_FLAG_FULL 0
`define FFLC_FLAG_EMPTY 1
`define FFLC_FLAG_AEMPTY 2
`define FFLC_RESP_OKAY 2'h0
`define FFLC_RESP_SLVERR 2'h2

// ****************************************
// counts
// ****************************************
`define FFLC_LA_EXTRA_WORDS 2
`define FFLC_SYNC_STAGES 2

`endif

//--- verilog/fflc_pkg.sv
// Purpose: shared types of the fill level counters
// Assumes: fflc_defines.svh on the include path
// Notes: widths that follow the queue depth live in the modules
`include "fflc_defines.svh"

package fflc_pkg;

   // ****************************************
   // control word
   // ****************************************
   typedef struct packed {
      logic fifo_rst;
      logic accurate;
      logic lookahead_read_mode;
   } fflc_ctrl_s;

   // ****************************************
   // bus slave states
   // ****************************************
   typedef enum logic [3:0] {
      WS_IDLE = 4'h1,
      WS_GOTA = 4'h2,
      WS_GOTW = 4'h4,
      WS_RESP = 4'h8
   } fflc_wst_e;

   typedef enum logic [1:0] {
      RS_IDLE = 2'h1,
      RS_DATA = 2'h2
   } fflc_rst_e;

endpackage

//--- verilog/fflc_ptr_sync.sv
// Purpose: moves a binary pointer into the observing side as gray code
// Assumes: source pointer steps by at most one per cycle
// Notes: four cycles from bin_in to bin_out
`timescale 1ns/100ps

module fflc_ptr_sync
   import fflc_pkg::*;
#(
   parameter int W = 6
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clear,
   input wire logic [W-1:0] bin_in,
   output logic [W-1:0] bin_out
);

   typedef struct packed {
      logic [W-1:0] gray;
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] bin;
   } fflc_sync_s;

   fflc_sync_s s_q;
   fflc_sync_s s_d;

   // ****************************************
   // gray helpers
   // ****************************************
   function automatic logic [W-1:0] gray2bin(input logic [W-1:0] g);
      logic [W-1:0] b;
      b = '0;
      b[W-1] = g[W-1];
      for (int i = W - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   // only one bit changes per step, so a torn sample is one step stale
   always_comb begin
      s_d = s_q;
      s_d.gray = bin_in ^ (bin_in >> 1);
      s_d.s1 = s_q.gray;
      s_d.s2 = s_q.s1; // s1 feeds nothing else
      s_d.bin = gray2bin(s_q.s2);
      if (clear) begin
         s_d = '0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign bin_out = s_q.bin;

endmodule

//--- sim/fflc_user_model.sv
// Purpose: user write and read logic on the far side of the fill counters
// Assumes: full sampled at the aclk rising edge
// Notes: requests drawn at random with a fixed seed; pct 8'h80 means always
`timescale 1ns/100ps

module fflc_user_model
   import fflc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic full,
   input wire logic [4:0] wr_count,
   input wire logic acc,
   input wire logic hold_half,
   input wire logic [7:0] wr_pct,
   input wire logic [7:0] rd_pct,
   output logic wr_en,
   output logic rd_en
);
   // ****************************************
   // request pacing
   // ****************************************
   integer seed = 61947;
   logic half_full;

   // accurate counts need both top bits, one bit alone misleads
   assign half_full = acc ? (wr_count[4] & wr_count[3]) : wr_count[3];

   // requests still offered while full so refusals get exercised
   always @(posedge aclk) begin
      if (!aresetn) begin
         wr_en <= 1'b0;
         rd_en <= 1'b0;
      end else begin
         wr_en <= (($random(seed) & 127) < wr_pct) && !(hold_half && half_full && !full);
         rd_en <= ($random(seed) & 127) < rd_pct;
      end
   end
endmodule

//--- sim/fflc_tb_top.sv
// Purpose: self-checking bench for the fill level counters
// Assumes: default queue depth 16, 1:1 port ratio
// Notes: fill level tracked from taken requests; bounds checked every cycle while mon is set
`timescale 1ns/100ps
`include "fflc_defines.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end

module fflc_tb_top
   import fflc_pkg::*;
;
   logic aclk, aresetn, hold_half, wr_en, rd_en, full, empty;
   logic [7:0] wr_pct, rd_pct, awaddr, araddr;
   logic [4:0] wr_count, rd_count, data_count;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, acc, la, frst, mon;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   int n_errors = 0;
   int n_checks = 0;
   int wtot, rtot, wprev, rprev, cap;

   // approximate counts stop at the top of a 4-bit field, accurate ones do not
   function automatic int exp_cnt(input logic acc_i, input int lvl);
      return (!acc_i && lvl > 15) ? 15 : lvl;
   endfunction

   fflc_top i_fflc_top (.aclk(aclk), .aresetn(aresetn), .wr_en(wr_en), .rd_en(rd_en),
      .full(full), .empty(empty), .wr_count(wr_count), .rd_count(rd_count),
      .data_count(data_count), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   fflc_user_model i_fflc_user_model (.aclk(aclk), .aresetn(aresetn), .full(full),
      .wr_count(wr_count), .acc(acc), .hold_half(hold_half), .wr_pct(wr_pct),
      .rd_pct(rd_pct), .wr_en(wr_en), .rd_en(rd_en));

   // ****************************************
   // clock, level tracking and bound checks
   // ****************************************
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   // true level from requests the queue accepted
   always @(posedge aclk) begin
      if (!aresetn || frst) begin
         wtot <= 0;
         rtot <= 0;
         wprev <= 0;
         rprev <= 0;
      end else begin
         wprev <= wtot;
         rprev <= rtot;
         if (wr_en && !full) wtot <= wtot + 1;
         if (rd_en && !empty) rtot <= rtot + 1;
      end
   end

   // previous-edge totals allow the one-cycle lag of the crossing counts
   always @(negedge aclk) begin
      if (mon) begin
         `CHK(wr_count >= exp_cnt(acc, wprev - rtot), 1'b1)
         `CHK(rd_count <= wtot - rprev, 1'b1)
         `CHK(data_count >= wtot - rtot && data_count <= wtot - rtot + (acc ? 2 : 0), 1'b1)
      end
   end

   // ****************************************
   // register bus master
   // ****************************************
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            done = 1'b1;
            bready <= 1'b0;
            `CHK(bresp, er)
         end
      end
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            done = 1'b1;
            rready <= 1'b0;
            `CHK(rdata, ed)
            `CHK(rresp, er)
         end
      end
   endtask

   // queue reset, then release with the chosen count style
   task automatic set_mode(input logic acc_i, input logic la_i);
      mon = 1'b0;
      frst = 1'b1;
      axi_wr(`FFLC_OFS_CTRL, {29'h0, 1'b1, acc_i, la_i}, `FFLC_RESP_OKAY);
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      `CHK({wr_count, data_count}, 10'h000)
      axi_wr(`FFLC_OFS_CTRL, {29'h0, 1'b0, acc_i, la_i}, `FFLC_RESP_OKAY);
      frst = 1'b0;
      acc = acc_i;
      la = la_i;
      repeat (10) @(posedge aclk);
      @(negedge aclk);
      `CHK(wr_count, {3'h0, acc && la, 1'b0})
      `CHK(rd_count, 5'h00)
      if (acc == la) `CHK(data_count, {3'h0, la, 1'b0})
      mon = 1'b1;
   endtask

   task complete_run;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial begin
      #(40 * 20000);
      n_errors++;
      complete_run;
   end

   initial begin
      {aresetn, hold_half, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
      {wr_pct, rd_pct, awaddr, araddr, wdata} = 64'h0;
      {acc, la, frst, mon} = 4'h0;
      wstrb = 4'hF;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      `CHK({full, empty, wr_count, rd_count, data_count}, 17'h18000)
      mon = 1'b1;
      axi_rd(`FFLC_OFS_CTRL, 32'h0, `FFLC_RESP_OKAY);
      axi_rd(8'h14, 32'h0, `FFLC_RESP_SLVERR);
      axi_wr(8'h14, 32'hFFFFFFFF, `FFLC_RESP_SLVERR);
      axi_wr(`FFLC_OFS_WCOUNT, 32'h1F, `FFLC_RESP_OKAY);
      axi_rd(`FFLC_OFS_WCOUNT, 32'h0, `FFLC_RESP_OKAY);
      // byte lane 0 off: the control write must be dropped
      wstrb <= 4'h0;
      axi_wr(`FFLC_OFS_CTRL, 32'h7, `FFLC_RESP_OKAY);
      axi_rd(`FFLC_OFS_CTRL, 32'h0, `FFLC_RESP_OKAY);
      wstrb <= 4'hF;
      // one write, then one read, timed edge by edge
      @(posedge aclk) wr_pct <= 8'h80;
      @(posedge aclk) wr_pct <= 8'h00;
      @(posedge aclk);
      @(negedge aclk) `CHK({wr_count, data_count}, 10'h001)
      @(negedge aclk) `CHK(wr_count, 5'h01)
      repeat (8) @(negedge aclk);
      `CHK({empty, rd_count}, 6'h01)
      @(posedge aclk) rd_pct <= 8'h80;
      @(posedge aclk) rd_pct <= 8'h00;
      @(posedge aclk);
      @(negedge aclk) `CHK({rd_count, data_count}, 10'h020)
      @(negedge aclk) `CHK(rd_count, 5'h00)
      for (int m = 0; m < 4; m++) begin
         set_mode(m[1], m[0]);
         cap = la ? 18 : 16;
         wr_pct <= 8'h40;
         rd_pct <= 8'h40;
         hold_half <= m[0];
         repeat (400) @(posedge aclk);
         // fill with the writer pushing on past full
         wr_pct <= 8'h80;
         rd_pct <= 8'h00;
         hold_half <= 1'b0;
         repeat (60) @(posedge aclk);
         @(negedge aclk);
         `CHK(full, 1'b1)
         `CHK(wtot - rtot, cap)
         axi_rd(`FFLC_OFS_WCOUNT, exp_cnt(acc, cap), `FFLC_RESP_OKAY);
         axi_rd(`FFLC_OFS_RCOUNT, exp_cnt(acc, cap), `FFLC_RESP_OKAY);
         axi_rd(`FFLC_OFS_DCOUNT, cap, `FFLC_RESP_OKAY);
         axi_rd(`FFLC_OFS_FLAGS, 32'h1, `FFLC_RESP_OKAY);
         // drain with reads still requested once empty
         wr_pct <= 8'h00;
         rd_pct <= 8'h80;
         repeat (60) @(posedge aclk);
         @(negedge aclk);
         `CHK(wtot - rtot, 0)
         `CHK({empty, rd_count}, 6'h20)
         `CHK(wr_count, {3'h0, acc && la, 1'b0})
      end
      complete_run;
   end
endmodule
